// ### axis_counter_environment.sv
// Counter environment, comparator setup register and the three axis position counters
// Functional notes
// - Third counter source: 000 command, 001 encoder, 010 pulser, 011 clock/4096.
// - Codes 100-110 count deviation between two sources; code 111 can be written and counts nothing.
// - Busy-gated bit lets third counter count only while busy output is low.
// - Per-counter bits clear that counter when the external clear input turns on.
// - Legacy bit checks error-stop causes at start write instead of motion start.
// - Per-counter bits clear that counter when origin return completes.
// - Per-counter bits allow counting during backlash correction; cleared suppresses it.
// - Per-counter count enable; cleared holds the counter value.
// - Comparator setup register written by one command code, read by another.
module axis_counter_environment #(
   parameter int CNT_W = axis_counter_pkg::CNT_W,
   parameter int DIV_RATIO = axis_counter_pkg::DIV_RATIO
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CMD_VALID_I,
   input wire logic [15:0] CMD_CODE_I,
   input wire logic [31:0] CMD_WDATA_I,
   output logic [31:0] RDATA_O,
   output logic RVALID_O,
   input wire logic ENCODER_PHASE_A_I,
   input wire logic ENCODER_PHASE_B_I,
   input wire logic PULSER_PHASE_A_I,
   input wire logic PULSER_PHASE_B_I,
   input wire logic EXTERNAL_CLEAR_I,
   input wire logic CMD_PULSE_UP_I,
   input wire logic CMD_PULSE_DN_I,
   input wire logic AXIS_OPERATING_FLAG_N_I,
   input wire logic BACKLASH_ACTIVE_I,
   input wire logic HOME_DONE_I,
   input wire logic START_WRITE_I,
   input wire logic MOTION_START_I,
   output logic ERROR_CHECK_O,
   output logic [CNT_W-1:0] COUNT1_O,
   output logic [CNT_W-1:0] COUNT2_O,
   output logic [CNT_W-1:0] COUNT3_O,
   output logic [31:0] COMPARATOR_SETUP_O
);
   localparam int DIV_W = $clog2(DIV_RATIO);

   axis_counter_pkg::counter_env_t env_reg;
   logic [31:0] cmp_reg;
   axis_counter_pkg::step_t enc_step;
   axis_counter_pkg::step_t pls_step;
   axis_counter_pkg::step_t cmd_step;
   logic [DIV_W-1:0] div_reg;
   logic div_tick;
   logic [2:0] clr_sync_reg;
   logic ext_clear_edge;
   logic signed [2:0] delta3;
   logic signed [2:0] delta [3];
   logic [2:0] gate;
   logic [2:0] clear;
   logic [CNT_W-1:0] cnt_reg [3];

   function automatic logic signed [2:0] step_val(input axis_counter_pkg::step_t s);
      logic signed [2:0] v;
      v = 3'sd0;
      if (s.up && !s.dn) begin
         v = 3'sd1;
      end else if (s.dn && !s.up) begin
         v = -3'sd1;
      end
      return v;
   endfunction

   assign cmd_step = '{up: CMD_PULSE_UP_I, dn: CMD_PULSE_DN_I};

   quad_step_decoder u_enc (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .PHASE_A_I(ENCODER_PHASE_A_I),
      .PHASE_B_I(ENCODER_PHASE_B_I),
      .STEP_O(enc_step)
   );

   quad_step_decoder u_pls (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .PHASE_A_I(PULSER_PHASE_A_I),
      .PHASE_B_I(PULSER_PHASE_B_I),
      .STEP_O(pls_step)
   );

   // Command decode and register writes
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         env_reg <= axis_counter_pkg::ENV_RESET;
         cmp_reg <= axis_counter_pkg::CMP_RESET;
      end else if (CMD_VALID_I) begin
         if (CMD_CODE_I == axis_counter_pkg::CMD_WR_ENV) begin
            env_reg <= CMD_WDATA_I & ~axis_counter_pkg::ENV_RSVD_MASK;
         end
         if (CMD_CODE_I == axis_counter_pkg::CMD_WR_CMP) begin
            cmp_reg <= CMD_WDATA_I;
         end
      end
   end

   // Read answer one cycle after the command; unknown codes give no answer
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         RDATA_O <= 32'h0000_0000;
         RVALID_O <= 1'b0;
      end else begin
         RVALID_O <= 1'b0;
         if (CMD_VALID_I && CMD_CODE_I == axis_counter_pkg::CMD_RD_ENV) begin
            RDATA_O <= env_reg & ~axis_counter_pkg::ENV_RSVD_MASK;
            RVALID_O <= 1'b1;
         end else if (CMD_VALID_I && CMD_CODE_I == axis_counter_pkg::CMD_RD_CMP) begin
            RDATA_O <= cmp_reg;
            RVALID_O <= 1'b1;
         end
      end
   end

   assign COMPARATOR_SETUP_O = cmp_reg;

   // Reference divider runs free; wrapping on the tick keeps any ratio exact
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         div_reg <= '0;
      end else if (div_tick) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end
   assign div_tick = (div_reg == DIV_W'(DIV_RATIO - 1));

   // Clear pin synchroniser; edge taken from the settled stages only
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         clr_sync_reg <= 3'h0;
      end else begin
         clr_sync_reg <= {clr_sync_reg[1:0], EXTERNAL_CLEAR_I};
      end
   end
   assign ext_clear_edge = clr_sync_reg[1] && !clr_sync_reg[2];

   // Error-stop check moment
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         ERROR_CHECK_O <= 1'b0;
      end else if (env_reg.legacy_error_check_timing) begin
         ERROR_CHECK_O <= START_WRITE_I;
      end else begin
         ERROR_CHECK_O <= MOTION_START_I;
      end
   end

   // Third counter source; code 111 counts nothing
   always_comb begin
      case (env_reg.third_counter_source)
         axis_counter_pkg::SRC_CMD: delta3 = step_val(cmd_step);
         axis_counter_pkg::SRC_ENC: delta3 = step_val(enc_step);
         axis_counter_pkg::SRC_PLS: delta3 = step_val(pls_step);
         axis_counter_pkg::SRC_DIV: delta3 = div_tick ? 3'sd1 : 3'sd0;
         axis_counter_pkg::SRC_CMD_ENC: delta3 = step_val(cmd_step) - step_val(enc_step);
         axis_counter_pkg::SRC_PLS_CMD: delta3 = step_val(pls_step) - step_val(cmd_step);
         axis_counter_pkg::SRC_PLS_ENC: delta3 = step_val(pls_step) - step_val(enc_step);
         default: delta3 = 3'sd0;
      endcase
   end

   assign delta[0] = step_val(cmd_step);
   assign delta[1] = step_val(enc_step);
   assign delta[2] = delta3;

   // Clear wins over a count in the same cycle
   for (genvar n = 0; n < 3; n++) begin : g_cnt
      assign clear[n] = (ext_clear_edge && env_reg.clear_on_ext[n])
         || (HOME_DONE_I && env_reg.clear_at_home[n]);
      assign gate[n] = env_reg.count_enable[n]
         && (!BACKLASH_ACTIVE_I || env_reg.counts_in_backlash[n])
         && (n != 2 || !env_reg.busy_gated_count || !AXIS_OPERATING_FLAG_N_I);
      always_ff @(posedge CLK_I) begin
         if (RST_I) begin
            cnt_reg[n] <= '0;
         end else if (clear[n]) begin
            cnt_reg[n] <= '0;
         end else if (gate[n]) begin
            cnt_reg[n] <= cnt_reg[n] + CNT_W'(delta[n]);
         end
      end
   end

   assign COUNT1_O = cnt_reg[0];
   assign COUNT2_O = cnt_reg[1];
   assign COUNT3_O = cnt_reg[2];

   a_div_source: assert property (@(posedge CLK_I) disable iff (RST_I)
      env_reg.third_counter_source == axis_counter_pkg::SRC_DIV && gate[2] && !clear[2]
      && div_tick |=> cnt_reg[2] == $past(cnt_reg[2]) + 1'b1)
      else $error("third counter missed divider tick");
   a_div_spacing: assert property (@(posedge CLK_I) disable iff (RST_I)
      div_tick |=> !div_tick [*8])
      else $error("divider ticks too close");
   a_deviation: assert property (@(posedge CLK_I) disable iff (RST_I)
      env_reg.third_counter_source == axis_counter_pkg::SRC_CMD_ENC && gate[2] && !clear[2]
      && cmd_step.up && !cmd_step.dn && enc_step.up && !enc_step.dn
      |=> $stable(cnt_reg[2]))
      else $error("deviation count moved on matched steps");
   a_busy_gate: assert property (@(posedge CLK_I) disable iff (RST_I)
      env_reg.busy_gated_count && AXIS_OPERATING_FLAG_N_I && !clear[2]
      |=> $stable(cnt_reg[2]))
      else $error("third counter moved while idle");
   a_ext_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
      $rose(clr_sync_reg[2]) && $past(env_reg.clear_on_ext[0]) |-> cnt_reg[0] == '0)
      else $error("external clear did not clear first counter");
   a_err_timing: assert property (@(posedge CLK_I) disable iff (RST_I)
      env_reg.legacy_error_check_timing && START_WRITE_I |=> ERROR_CHECK_O)
      else $error("legacy error check missed start write");
   a_home_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
      HOME_DONE_I && env_reg.clear_at_home[2] |=> cnt_reg[2] == '0)
      else $error("home completion did not clear third counter");
   a_backlash_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
      BACKLASH_ACTIVE_I && !env_reg.counts_in_backlash[0] && !clear[0]
      |=> $stable(cnt_reg[0]))
      else $error("first counter moved in backlash");
   a_count_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
      !env_reg.count_enable[1] && !clear[1] |=> $stable(cnt_reg[1]))
      else $error("disabled second counter moved");
   a_cmp_readback: assert property (@(posedge CLK_I) disable iff (RST_I)
      CMD_VALID_I && CMD_CODE_I == axis_counter_pkg::CMD_WR_CMP ##1
      CMD_VALID_I && CMD_CODE_I == axis_counter_pkg::CMD_RD_CMP
      |=> RVALID_O && RDATA_O == $past(CMD_WDATA_I, 2))
      else $error("comparator setup readback mismatch");
   a_rsvd_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
      RVALID_O |-> (RDATA_O & axis_counter_pkg::ENV_RSVD_MASK) == '0
      || $past(CMD_CODE_I) == axis_counter_pkg::CMD_RD_CMP)
      else $error("reserved environment bits read nonzero");

   // Checks on the remaining counters, on the error-check moment and on the command registers
   a_ext_clear_third: assert property (@(posedge CLK_I) disable iff (RST_I)
      $rose(clr_sync_reg[2]) && $past(env_reg.clear_on_ext[2]) |-> cnt_reg[2] == '0)
      else $error("external clear did not clear third counter");
   a_ext_clear_off: assert property (@(posedge CLK_I) disable iff (RST_I)
      ext_clear_edge && !env_reg.clear_on_ext[1] && !HOME_DONE_I
      && !enc_step.up && !enc_step.dn |=> $stable(cnt_reg[1]))
      else $error("second counter reacted to a disabled clear");
   a_home_clear_first: assert property (@(posedge CLK_I) disable iff (RST_I)
      HOME_DONE_I && env_reg.clear_at_home[0] |=> cnt_reg[0] == '0)
      else $error("home completion did not clear first counter");
   a_home_clear_second: assert property (@(posedge CLK_I) disable iff (RST_I)
      HOME_DONE_I && env_reg.clear_at_home[1] |=> cnt_reg[1] == '0)
      else $error("home completion did not clear second counter");
   a_backlash_third: assert property (@(posedge CLK_I) disable iff (RST_I)
      BACKLASH_ACTIVE_I && !env_reg.counts_in_backlash[2] && !clear[2]
      |=> $stable(cnt_reg[2]))
      else $error("third counter moved in backlash");
   a_backlash_count: assert property (@(posedge CLK_I) disable iff (RST_I)
      BACKLASH_ACTIVE_I && env_reg.counts_in_backlash[0] && env_reg.count_enable[0]
      && !clear[0] && cmd_step.up && !cmd_step.dn
      |=> cnt_reg[0] == $past(cnt_reg[0]) + 1'b1)
      else $error("first counter missed a step in backlash");
   a_count_first: assert property (@(posedge CLK_I) disable iff (RST_I)
      env_reg.count_enable[0] && !BACKLASH_ACTIVE_I && !clear[0]
      && cmd_step.dn && !cmd_step.up
      |=> cnt_reg[0] == $past(cnt_reg[0]) - 1'b1)
      else $error("enabled first counter missed a down step");
   a_hold_third: assert property (@(posedge CLK_I) disable iff (RST_I)
      !env_reg.count_enable[2] && !clear[2] |=> $stable(cnt_reg[2]))
      else $error("disabled third counter moved");
   a_busy_count: assert property (@(posedge CLK_I) disable iff (RST_I)
      env_reg.busy_gated_count && !AXIS_OPERATING_FLAG_N_I && env_reg.count_enable[2]
      && !BACKLASH_ACTIVE_I && env_reg.third_counter_source == axis_counter_pkg::SRC_CMD
      && !clear[2] && cmd_step.up && !cmd_step.dn
      |=> cnt_reg[2] == $past(cnt_reg[2]) + 1'b1)
      else $error("third counter missed a step while busy");
   a_deviation_enc: assert property (@(posedge CLK_I) disable iff (RST_I)
      env_reg.third_counter_source == axis_counter_pkg::SRC_CMD_ENC && gate[2] && !clear[2]
      && enc_step.up && !enc_step.dn && !cmd_step.up && !cmd_step.dn
      |=> cnt_reg[2] == $past(cnt_reg[2]) - 1'b1)
      else $error("deviation count missed an encoder step");
   a_deviation_pls: assert property (@(posedge CLK_I) disable iff (RST_I)
      env_reg.third_counter_source == axis_counter_pkg::SRC_PLS_ENC && gate[2] && !clear[2]
      && pls_step.up && !pls_step.dn && !enc_step.up && !enc_step.dn
      |=> cnt_reg[2] == $past(cnt_reg[2]) + 1'b1)
      else $error("deviation count missed a pulser step");
   a_err_normal: assert property (@(posedge CLK_I) disable iff (RST_I)
      !env_reg.legacy_error_check_timing && MOTION_START_I |=> ERROR_CHECK_O)
      else $error("error check missed motion start");
   a_err_quiet: assert property (@(posedge CLK_I) disable iff (RST_I)
      env_reg.legacy_error_check_timing && !START_WRITE_I |=> !ERROR_CHECK_O)
      else $error("legacy error check fired without start write");
   a_cmp_output: assert property (@(posedge CLK_I) disable iff (RST_I)
      CMD_VALID_I && CMD_CODE_I == axis_counter_pkg::CMD_WR_CMP
      |=> COMPARATOR_SETUP_O == $past(CMD_WDATA_I))
      else $error("comparator setup output missed a write");
   a_no_answer: assert property (@(posedge CLK_I) disable iff (RST_I)
      !CMD_VALID_I |=> !RVALID_O)
      else $error("read answer without a command");
   a_env_masked: assert property (@(posedge CLK_I) disable iff (RST_I)
      CMD_VALID_I && CMD_CODE_I == axis_counter_pkg::CMD_WR_ENV
      |=> (env_reg & axis_counter_pkg::ENV_RSVD_MASK) == '0)
      else $error("undefined environment bits were stored");

   c_ext_clear: cover property (@(posedge CLK_I) disable iff (RST_I)
      ext_clear_edge && env_reg.clear_on_ext[0]);
   c_deviation: cover property (@(posedge CLK_I) disable iff (RST_I)
      env_reg.third_counter_source == axis_counter_pkg::SRC_PLS_ENC && delta3 != 3'sd0);
   c_div_count: cover property (@(posedge CLK_I) disable iff (RST_I)
      env_reg.third_counter_source == axis_counter_pkg::SRC_DIV && gate[2] && div_tick);
   c_home: cover property (@(posedge CLK_I) disable iff (RST_I)
      HOME_DONE_I && env_reg.clear_at_home != 3'h0);
   c_back_to_back: cover property (@(posedge CLK_I) disable iff (RST_I)
      CMD_VALID_I && CMD_CODE_I == axis_counter_pkg::CMD_WR_CMP ##1
      CMD_VALID_I && CMD_CODE_I == axis_counter_pkg::CMD_RD_CMP);
endmodule

// ### axis_counter_pkg.sv
// Shared constants, field layouts and carriers for the axis counter environment
package axis_counter_pkg;
   localparam int CNT_W = 32;
   localparam logic [15:0] CMD_WR_ENV = 16'h009e;
   localparam logic [15:0] CMD_RD_ENV = 16'h00de;
   localparam logic [15:0] CMD_WR_CMP = 16'h009f;
   localparam logic [15:0] CMD_RD_CMP = 16'h00df;
   localparam logic [31:0] ENV_RESET = 32'h0000_0000;
   localparam logic [31:0] CMP_RESET = 32'h0000_0000;
   localparam logic [31:0] ENV_RSVD_MASK = 32'h8880_c000;
   localparam int DIV_RATIO = 4096;
   localparam logic [2:0] SRC_CMD = 3'h0;
   localparam logic [2:0] SRC_ENC = 3'h1;
   localparam logic [2:0] SRC_PLS = 3'h2;
   localparam logic [2:0] SRC_DIV = 3'h3;
   localparam logic [2:0] SRC_CMD_ENC = 3'h4;
   localparam logic [2:0] SRC_PLS_CMD = 3'h5;
   localparam logic [2:0] SRC_PLS_ENC = 3'h6;

   typedef struct packed {
      logic up;
      logic dn;
   } step_t;

   typedef struct packed {
      logic rsvd31;
      logic [2:0] count_enable;
      logic rsvd27;
      logic [2:0] counts_in_backlash;
      logic rsvd23;
      logic [2:0] clear_at_home;
      logic legacy_error_check_timing;
      logic [2:0] clear_on_ext;
      logic [1:0] rsvd15_14;
      logic busy_gated_count;
      logic [2:0] third_counter_source;
      logic [9:0] low_fields;
   } counter_env_t;
endpackage

// ### quad_phase_model.sv
// Behavioural quadrature source standing in for an encoder or a manual pulser
module quad_phase_model (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic STEP_UP_I,
   output logic PHASE_A_O,
   output logic PHASE_B_O
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] phase_reg;
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         phase_reg <= 2'h0;
      end else if (STEP_UP_I) begin
         phase_reg <= phase_reg + 2'h1;
      end
   end
   // Gray order 00,10,11,01 so one request moves exactly one quarter step forward
   assign PHASE_A_O = phase_reg[0] ^ phase_reg[1];
   assign PHASE_B_O = phase_reg[1];
endmodule

// ### quad_step_decoder.sv
// Two-phase input synchroniser and 4x quadrature step decoder
module quad_step_decoder (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic PHASE_A_I,
   input wire logic PHASE_B_I,
   output axis_counter_pkg::step_t STEP_O
);
   logic [1:0] meta_reg;
   logic [1:0] sync_reg;
   logic [1:0] prev_reg;
   axis_counter_pkg::step_t step_next;

   // First stage is read only by the second stage
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         meta_reg <= 2'h0;
         sync_reg <= 2'h0;
         prev_reg <= 2'h0;
      end else begin
         meta_reg <= {PHASE_A_I, PHASE_B_I};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Gray sequence 00-10-11-01 counts up; a double jump is dropped as noise
   always_comb begin
      step_next = '0;
      case ({prev_reg, sync_reg})
         4'b0010, 4'b1011, 4'b1101, 4'b0100: step_next.up = 1'b1;
         4'b0001, 4'b0111, 4'b1110, 4'b1000: step_next.dn = 1'b1;
         default: step_next = '0;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         STEP_O <= '0;
      end else begin
         STEP_O <= step_next;
      end
   end
endmodule

// ### tb_top.sv
// Self-checking bench for the axis counter environment
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DIV = 16;
   logic clk, rst, valid, ext_clr, busy_n, backlash, rvalid, err;
   logic cmd_up, cmd_dn, enc_step, pls_step, home, start_wr, motion_st;
   logic enc_a, enc_b, pls_a, pls_b;
   logic [15:0] code;
   logic [31:0] wdata, rdata, cmp, c1, c2, c3;
   int miscompares, samples_checked;
   axis_counter_environment #(.DIV_RATIO(DIV)) u_dut (.CLK_I(clk), .RST_I(rst),
      .CMD_VALID_I(valid), .CMD_CODE_I(code), .CMD_WDATA_I(wdata), .RDATA_O(rdata),
      .RVALID_O(rvalid), .ENCODER_PHASE_A_I(enc_a), .ENCODER_PHASE_B_I(enc_b),
      .PULSER_PHASE_A_I(pls_a), .PULSER_PHASE_B_I(pls_b), .EXTERNAL_CLEAR_I(ext_clr),
      .CMD_PULSE_UP_I(cmd_up), .CMD_PULSE_DN_I(cmd_dn), .AXIS_OPERATING_FLAG_N_I(busy_n),
      .BACKLASH_ACTIVE_I(backlash), .HOME_DONE_I(home), .START_WRITE_I(start_wr),
      .MOTION_START_I(motion_st), .ERROR_CHECK_O(err), .COUNT1_O(c1), .COUNT2_O(c2),
      .COUNT3_O(c3), .COMPARATOR_SETUP_O(cmp));
   quad_phase_model u_enc (.CLK_I(clk), .RST_I(rst), .STEP_UP_I(enc_step),
      .PHASE_A_O(enc_a), .PHASE_B_O(enc_b));
   quad_phase_model u_pls (.CLK_I(clk), .RST_I(rst), .STEP_UP_I(pls_step),
      .PHASE_A_O(pls_a), .PHASE_B_O(pls_b));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask
   task automatic bus(input logic [15:0] c, input logic [31:0] d);
      @(negedge clk);
      valid = 1'b1;
      code = c;
      wdata = d;
      @(negedge clk);
      valid = 1'b0;
   endtask
   // Answer stands one cycle only, so it is judged at the first falling edge
   task automatic rd(input string name, input logic [15:0] c, input logic [31:0] exp);
      bus(c, 32'h0);
      chk("rvalid", 32'h1, {31'h0, rvalid});
      chk(name, exp, rdata);
   endtask
   task automatic pulse(input int sel);
      @(negedge clk);
      case (sel)
         0: cmd_up = 1'b1;
         1: enc_step = 1'b1;
         2: pls_step = 1'b1;
         3: home = 1'b1;
         4: start_wr = 1'b1;
         6: cmd_dn = 1'b1;
         default: motion_st = 1'b1;
      endcase
      @(negedge clk);
      {cmd_up, cmd_dn, enc_step, pls_step, home, start_wr, motion_st} = 7'h0;
   endtask
   task automatic t_regs;
      chk("count1 rst", 32'h0, c1);
      rd("env rst", axis_counter_pkg::CMD_RD_ENV, axis_counter_pkg::ENV_RESET);
      rd("cmp rst", axis_counter_pkg::CMD_RD_CMP, axis_counter_pkg::CMP_RESET);
      bus(axis_counter_pkg::CMD_WR_CMP, 32'ha5c3_0f96);
      rd("cmp rd", axis_counter_pkg::CMD_RD_CMP, 32'ha5c3_0f96);
      chk("cmp out", 32'ha5c3_0f96, cmp);
      // Write then read on consecutive edges, which the command bus allows
      @(negedge clk);
      valid = 1'b1;
      code = axis_counter_pkg::CMD_WR_CMP;
      wdata = 32'h5a3c_f069;
      @(negedge clk);
      code = axis_counter_pkg::CMD_RD_CMP;
      wdata = 32'h0;
      @(negedge clk);
      valid = 1'b0;
      chk("b2b rvalid", 32'h1, {31'h0, rvalid});
      chk("b2b cmp rd", 32'h5a3c_f069, rdata);
      // Undefined positions are always written as zero
      bus(axis_counter_pkg::CMD_WR_ENV, 32'h777f_23ff);
      rd("env rd", axis_counter_pkg::CMD_RD_ENV, 32'h777f_23ff);
      bus(16'h0011, 32'h0);
      chk("unknown code", 32'h0, {31'h0, rvalid});
      $display("test registers done");
   endtask
   task automatic t_sources;
      logic [31:0] exp [7] = '{32'h1, 32'h2, 32'h3, 32'h0, 32'hffff_ffff, 32'h2, 32'h1};
      logic [31:0] v0;
      // Each pass: one command pulse, two encoder steps, three pulser steps
      for (int s = 0; s < 7; s++) begin
         if (s == 3) continue;
         bus(axis_counter_pkg::CMD_WR_ENV, 32'h7070_0000 | (32'(s) << 10));
         pulse(3);
         pulse(0);
         repeat (2) pulse(1);
         repeat (3) pulse(2);
         repeat (8) @(negedge clk);
         chk("count3 source", exp[s], c3);
      end
      // Down pulses count backwards on both command-fed counters
      bus(axis_counter_pkg::CMD_WR_ENV, 32'h7070_0000);
      pulse(3);
      repeat (2) pulse(6);
      pulse(0);
      chk("count1 down", 32'hffff_ffff, c1);
      chk("count3 down", 32'hffff_ffff, c3);
      bus(axis_counter_pkg::CMD_WR_ENV, 32'h4000_0c00);
      v0 = c3;
      // Any window of ten periods holds exactly ten divider ticks
      repeat (10 * DIV) @(negedge clk);
      chk("count3 divider", v0 + 32'd10, c3);
      $display("test sources done");
   endtask
   task automatic t_gating;
      bus(axis_counter_pkg::CMD_WR_ENV, 32'h5070_2000);
      pulse(3);
      pulse(0);
      pulse(1);
      repeat (6) @(negedge clk);
      chk("c1 enabled", 32'h1, c1);
      chk("c2 disabled", 32'h0, c2);
      chk("c3 not busy", 32'h0, c3);
      busy_n = 1'b0;
      pulse(0);
      repeat (3) @(negedge clk);
      chk("c3 busy", 32'h1, c3);
      backlash = 1'b1;
      bus(axis_counter_pkg::CMD_WR_ENV, 32'h5170_2000);
      pulse(0);
      repeat (3) @(negedge clk);
      chk("c1 backlash", 32'h3, c1);
      chk("c3 backlash", 32'h1, c3);
      backlash = 1'b0;
      busy_n = 1'b1;
      $display("test gating done");
   endtask
   task automatic t_clear;
      bus(axis_counter_pkg::CMD_WR_ENV, 32'h7070_0000);
      pulse(3);
      pulse(0);
      pulse(1);
      repeat (8) @(negedge clk);
      bus(axis_counter_pkg::CMD_WR_ENV, 32'h7005_0000);
      ext_clr = 1'b1;
      repeat (6) @(negedge clk);
      chk("c1 ext", 32'h0, c1);
      chk("c2 ext off", 32'h1, c2);
      chk("c3 ext", 32'h0, c3);
      pulse(0);
      repeat (3) @(negedge clk);
      chk("c1 level held", 32'h1, c1);
      ext_clr = 1'b0;
      bus(axis_counter_pkg::CMD_WR_ENV, 32'h7020_0000);
      pulse(3);
      repeat (2) @(negedge clk);
      chk("c2 home", 32'h0, c2);
      chk("c1 home off", 32'h1, c1);
      $display("test clears done");
   endtask
   task automatic t_errchk;
      bus(axis_counter_pkg::CMD_WR_ENV, 32'h0008_0000);
      pulse(4);
      chk("legacy write", 32'h1, {31'h0, err});
      pulse(5);
      chk("legacy start", 32'h0, {31'h0, err});
      bus(axis_counter_pkg::CMD_WR_ENV, 32'h0);
      pulse(4);
      chk("normal write", 32'h0, {31'h0, err});
      pulse(5);
      chk("normal start", 32'h1, {31'h0, err});
      $display("test error check done");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      conclude;
   end
   initial begin
      {rst, valid, ext_clr, busy_n, backlash, code, wdata} = {5'b10010, 48'h0};
      {cmd_up, cmd_dn, enc_step, pls_step, home, start_wr, motion_st} = 7'h0;
      miscompares = 0;
      samples_checked = 0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_regs;
      t_sources;
      t_gating;
      t_clear;
      t_errchk;
      conclude;
   end
endmodule
